/* src/cpu8_opcode_decode_subset.sv */
// Summary of operation
// - A three-bit register field means B 000, C 001, D 010, E 011, H 100, L 101, A 111, memory 110.
// - Conditional calls and returns report the short or long state count by the tested flag.
// - The pair-to-stack-pointer copy moves H and L into the stack pointer in 5 states.
// - Register compare tests the low-field register against the accumulator in 4 states.
// - Memory compare tests the byte at HL against the accumulator in 7 states.
// - Immediate compare tests the byte after the opcode against the accumulator in 7 states.
// - Immediate and leaves accumulator AND following byte in the accumulator in 7 states.
// - Double add with stack pointer puts HL plus SP back into HL in 10 states.
// - Rotate left via carry moves carry into bit 0 and bit 7 into carry in 4 states.
// - Rotate right via carry moves carry into bit 7 and bit 0 into carry in 4 states.
`timescale 1ns/1ns
`include "opdec_cfg.svh"

module cpu8_opcode_decode_subset (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Opcode from fetch stage
  input wire logic op_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand_i,
  // Register preload
  input wire logic wr_en_i,
  input wire logic [2:0] wr_field_i,
  input wire logic [7:0] wr_data_i,
  // Decode result
  output logic done_o,
  output opdec_pkg::insn_kind_type kind_o,
  output logic [4:0] state_count_o,
  output logic cond_taken_o,
  output logic operand_used_o,
  output logic unsupported_o,
  // Architectural state
  output logic [7:0] acc_o,
  output logic [15:0] hl_o,
  output logic [15:0] sp_o,
  output logic [7:0] flags_o
);
  import opdec_pkg::*;

  logic [7:0] a_r;
  logic [7:0] b_r;
  logic [7:0] c_r;
  logic [7:0] d_r;
  logic [7:0] e_r;
  logic [7:0] h_r;
  logic [7:0] l_r;
  logic [15:0] sp_r;
  logic [7:0] flags_r;
  logic done_r;
  insn_kind_type kind_r;
  logic [4:0] count_r;
  logic cond_taken_r;
  logic operand_used_r;
  logic unsupported_r;

  function automatic logic cond_holds(input logic [2:0] code, input logic [7:0] f);
    logic res;
    res = 1'b0;
    unique case (code)
      `COND_NZ: res = ~f[`FLAG_Z_BIT];
      `COND_Z: res = f[`FLAG_Z_BIT];
      `COND_NC: res = ~f[`FLAG_CY_BIT];
      `COND_C: res = f[`FLAG_CY_BIT];
      `COND_PO: res = ~f[`FLAG_P_BIT];
      `COND_PE: res = f[`FLAG_P_BIT];
      `COND_P: res = ~f[`FLAG_S_BIT];
      `COND_M: res = f[`FLAG_S_BIT];
    endcase
    return res;
  endfunction

  // Opcode classification
  wire logic [15:0] hl_w = {h_r, l_r};
  wire logic cy_w = flags_r[`FLAG_CY_BIT];
  wire logic [2:0] src_field_w = opcode_i[2:0];
  wire logic [2:0] cond_field_w = opcode_i[5:3];
  wire logic cmp_group_w = opcode_i[7:3] == `OP_CMP_PREFIX;
  wire logic src_is_mem_w;
  wire logic [7:0] src_value_w;
  wire logic is_pair_to_stack_pointer_w = opcode_i == `OP_PAIR_TO_STACK_POINTER;
  wire logic is_cmp_reg_w = cmp_group_w && !src_is_mem_w;
  wire logic is_cmp_mem_w = cmp_group_w && src_is_mem_w;
  wire logic is_cpi_w = opcode_i == `OP_CPI;
  wire logic is_ani_w = opcode_i == `OP_ANI;
  wire logic is_dad_sp_w = opcode_i == `OP_DAD_SP;
  wire logic is_ral_w = opcode_i == `OP_RAL;
  wire logic is_rar_w = opcode_i == `OP_RAR;
  wire logic cond_top_w = opcode_i[7:6] == `OP_COND_TOP;
  wire logic is_call_cond_w = cond_top_w && (opcode_i[2:0] == `OP_CALL_LOW);
  wire logic is_ret_cond_w = cond_top_w && (opcode_i[2:0] == `OP_RET_LOW);
  wire logic is_cmp_any_w = is_cmp_reg_w || is_cmp_mem_w || is_cpi_w;
  wire logic cond_met_w = cond_holds(cond_field_w, flags_r);
  wire logic uses_operand_w = is_cmp_mem_w || is_cpi_w || is_ani_w;

  reg_field_select u_src_sel (
    .field_i(src_field_w),
    .b_i(b_r),
    .c_i(c_r),
    .d_i(d_r),
    .e_i(e_r),
    .h_i(h_r),
    .l_i(l_r),
    .a_i(a_r),
    .mem_i(operand_i),
    .value_o(src_value_w),
    .is_mem_o(src_is_mem_w)
  );

  wire logic [7:0] cmp_operand_w = is_cmp_reg_w ? src_value_w : operand_i;
  wire logic [7:0] cmp_flags_w;
  wire logic [7:0] and_result_w;
  wire logic [7:0] and_flags_w;
  wire logic [7:0] ral_result_w;
  wire logic [7:0] rar_result_w;
  wire logic [7:0] ral_flags_w;
  wire logic [7:0] rar_flags_w;
  wire logic [15:0] dad_sum_w;
  wire logic [7:0] dad_flags_w;

  alu_unit u_alu (
    .a_i(a_r),
    .operand_i(cmp_operand_w),
    .carry_i(cy_w),
    .flags_i(flags_r),
    .hl_i(hl_w),
    .sp_i(sp_r),
    .cmp_flags_o(cmp_flags_w),
    .and_result_o(and_result_w),
    .and_flags_o(and_flags_w),
    .ral_result_o(ral_result_w),
    .rar_result_o(rar_result_w),
    .ral_flags_o(ral_flags_w),
    .rar_flags_o(rar_flags_w),
    .dad_sum_o(dad_sum_w),
    .dad_flags_o(dad_flags_w)
  );

  // Kind and state count selection
  wire insn_kind_type kind_nxt = is_pair_to_stack_pointer_w ? KIND_PAIR_TO_STACK_POINTER :
                                 is_cmp_reg_w ? KIND_CMP_REG :
                                 is_cmp_mem_w ? KIND_CMP_MEM :
                                 is_cpi_w ? KIND_CMP_IMM :
                                 is_ani_w ? KIND_ANI :
                                 is_dad_sp_w ? KIND_DAD_SP :
                                 is_ral_w ? KIND_RAL :
                                 is_rar_w ? KIND_RAR :
                                 is_call_cond_w ? KIND_CALL_COND :
                                 is_ret_cond_w ? KIND_RET_COND : KIND_NONE;
  // taken condition gives the long count
  wire logic [4:0] call_count_w = cond_met_w ? `CYC_CALL_LONG : `CYC_CALL_SHORT;
  wire logic [4:0] ret_count_w = cond_met_w ? `CYC_RET_LONG : `CYC_RET_SHORT;
  wire logic [4:0] count_nxt = is_pair_to_stack_pointer_w ? `CYC_PAIR_TO_STACK_POINTER :
                               is_cmp_reg_w ? `CYC_CMP_REG :
                               is_cmp_mem_w ? `CYC_CMP_MEM :
                               is_cpi_w ? `CYC_CPI :
                               is_ani_w ? `CYC_ANI :
                               is_dad_sp_w ? `CYC_DAD :
                               (is_ral_w || is_rar_w) ? `CYC_ROTATE :
                               is_call_cond_w ? call_count_w :
                               is_ret_cond_w ? ret_count_w : `CYC_NONE;

  // Accumulator, flag and pair updates
  wire logic [7:0] a_nxt = is_ani_w ? and_result_w :
                           is_ral_w ? ral_result_w :
                           is_rar_w ? rar_result_w : a_r;
  wire logic [7:0] flags_nxt = is_cmp_any_w ? cmp_flags_w :
                               is_ani_w ? and_flags_w :
                               is_ral_w ? ral_flags_w :
                               is_rar_w ? rar_flags_w :
                               is_dad_sp_w ? dad_flags_w : flags_r;
  wire logic [15:0] hl_nxt = is_dad_sp_w ? dad_sum_w : hl_w;
  wire logic [15:0] sp_nxt = is_pair_to_stack_pointer_w ? hl_w : sp_r;
  // Fixed flag bits survive a preload of the flag byte
  wire logic [7:0] wr_flags_w = (wr_data_i & 8'hd5) | `FLAGS_FIXED;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_r <= `RESET_BYTE;
      h_r <= `RESET_BYTE;
      l_r <= `RESET_BYTE;
      sp_r <= `RESET_SP;
      flags_r <= `FLAGS_FIXED;
    end else if (op_valid_i) begin
      a_r <= a_nxt;
      flags_r <= flags_nxt;
      {h_r, l_r} <= hl_nxt;
      sp_r <= sp_nxt;
    end else if (wr_en_i) begin
      // Memory code has no register, so it reaches the flag byte instead
      if (wr_field_i == `FIELD_A) begin
        a_r <= wr_data_i;
      end
      if (wr_field_i == `FIELD_H) begin
        h_r <= wr_data_i;
      end
      if (wr_field_i == `FIELD_L) begin
        l_r <= wr_data_i;
      end
      if (wr_field_i == `FIELD_MEM) begin
        flags_r <= wr_flags_w;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      b_r <= `RESET_BYTE;
      c_r <= `RESET_BYTE;
      d_r <= `RESET_BYTE;
      e_r <= `RESET_BYTE;
    end else if (!op_valid_i && wr_en_i) begin
      if (wr_field_i == `FIELD_B) begin
        b_r <= wr_data_i;
      end
      if (wr_field_i == `FIELD_C) begin
        c_r <= wr_data_i;
      end
      if (wr_field_i == `FIELD_D) begin
        d_r <= wr_data_i;
      end
      if (wr_field_i == `FIELD_E) begin
        e_r <= wr_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_r <= 1'b0;
      kind_r <= KIND_NONE;
      count_r <= `CYC_NONE;
      cond_taken_r <= 1'b0;
      operand_used_r <= 1'b0;
      unsupported_r <= 1'b0;
    end else begin
      done_r <= op_valid_i;
      unsupported_r <= op_valid_i && (kind_nxt == KIND_NONE);
      if (op_valid_i) begin
        kind_r <= kind_nxt;
        count_r <= count_nxt;
        cond_taken_r <= (is_call_cond_w || is_ret_cond_w) && cond_met_w;
        operand_used_r <= uses_operand_w;
      end
    end
  end

  assign done_o = done_r;
  assign kind_o = kind_r;
  assign state_count_o = count_r;
  assign cond_taken_o = cond_taken_r;
  assign operand_used_o = operand_used_r;
  assign unsupported_o = unsupported_r;
  assign acc_o = a_r;
  assign hl_o = hl_w;
  assign sp_o = sp_r;
  assign flags_o = flags_r;

  chk_field_mem_sel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && cmp_group_w && (opcode_i[2:0] == `FIELD_MEM)
    |=> kind_o == KIND_CMP_MEM && operand_used_o)
    else $error("Memory field code not decoded as memory operand");

  chk_cond_count: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_call_cond_w
    |=> state_count_o == ($past(cond_met_w) ? `CYC_CALL_LONG : `CYC_CALL_SHORT)
        && cond_taken_o == $past(cond_met_w))
    else $error("Conditional call state count wrong");

  chk_ret_count: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_ret_cond_w
    |=> state_count_o == ($past(cond_met_w) ? `CYC_RET_LONG : `CYC_RET_SHORT))
    else $error("Conditional return state count wrong");

  chk_pair_to_stack_pointer_copy: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_pair_to_stack_pointer_w |=> sp_o == $past(hl_w) && state_count_o == `CYC_PAIR_TO_STACK_POINTER)
    else $error("Stack pointer load from HL wrong");

  chk_cmp_reg_op: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_cmp_reg_w
    |=> state_count_o == `CYC_CMP_REG
        && flags_o[`FLAG_Z_BIT] == ($past(src_value_w) == $past(a_r)))
    else $error("Register compare wrong");

  chk_cmp_mem_op: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_cmp_mem_w
    |=> state_count_o == `CYC_CMP_MEM
        && flags_o[`FLAG_CY_BIT] == ($past(operand_i) > $past(a_r)))
    else $error("Memory compare wrong");

  chk_cpi_op: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_cpi_w
    |=> state_count_o == `CYC_CPI && operand_used_o
        && flags_o[`FLAG_Z_BIT] == ($past(operand_i) == $past(a_r)))
    else $error("Immediate compare wrong");

  chk_ani_result: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_ani_w
    |=> acc_o == ($past(a_r) & $past(operand_i)) && state_count_o == `CYC_ANI)
    else $error("Immediate and result wrong");

  chk_dad_sum: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_dad_sp_w
    |=> {flags_o[`FLAG_CY_BIT], hl_o} == ({1'b0, $past(hl_w)} + {1'b0, $past(sp_r)})
        && state_count_o == `CYC_DAD)
    else $error("Double add with stack pointer wrong");

  chk_ral_shift: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_ral_w
    |=> {cy_w, a_r} == {$past(a_r), $past(cy_w)} && state_count_o == `CYC_ROTATE)
    else $error("Rotate left via carry wrong");

  chk_rar_shift: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_rar_w
    |=> {a_r, cy_w} == {$past(cy_w), $past(a_r)} && state_count_o == `CYC_ROTATE)
    else $error("Rotate right via carry wrong");

  chk_cmp_keeps_acc: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    op_valid_i && is_cmp_any_w
    |=> acc_o == $past(a_r)
        && flags_o[`FLAG_S_BIT] == (8'($past(a_r) - $past(cmp_operand_w)) >= 8'h80))
    else $error("Compare changed the accumulator or sign flag wrong");

endmodule // cpu8_opcode_decode_subset

/* src/opdec_cfg.svh */
`ifndef OPDEC_CFG_SVH
`define OPDEC_CFG_SVH

// Three-bit register field codes
`define FIELD_B 3'h0
`define FIELD_C 3'h1
`define FIELD_D 3'h2
`define FIELD_E 3'h3
`define FIELD_H 3'h4
`define FIELD_L 3'h5
`define FIELD_MEM 3'h6
`define FIELD_A 3'h7

// Opcodes and opcode patterns
`define OP_PAIR_TO_STACK_POINTER 8'hf9
`define OP_CMP_PREFIX 5'h17
`define OP_CPI 8'hfe
`define OP_ANI 8'he6
`define OP_DAD_SP 8'h39
`define OP_RAL 8'h17
`define OP_RAR 8'h1f
`define OP_COND_TOP 2'h3
`define OP_CALL_LOW 3'h4
`define OP_RET_LOW 3'h0

// Condition codes in opcode bits 5:3
`define COND_NZ 3'h0
`define COND_Z 3'h1
`define COND_NC 3'h2
`define COND_C 3'h3
`define COND_PO 3'h4
`define COND_PE 3'h5
`define COND_P 3'h6
`define COND_M 3'h7

// Clock-state counts
`define CYC_NONE 5'h00
`define CYC_PAIR_TO_STACK_POINTER 5'h05
`define CYC_CMP_REG 5'h04
`define CYC_CMP_MEM 5'h07
`define CYC_CPI 5'h07
`define CYC_ANI 5'h07
`define CYC_DAD 5'h0a
`define CYC_ROTATE 5'h04
`define CYC_CALL_SHORT 5'h0b
`define CYC_CALL_LONG 5'h11
`define CYC_RET_SHORT 5'h05
`define CYC_RET_LONG 5'h0b

// Flag byte layout
`define FLAG_S_BIT 7
`define FLAG_Z_BIT 6
`define FLAG_AC_BIT 4
`define FLAG_P_BIT 2
`define FLAG_CY_BIT 0
`define FLAGS_FIXED 8'h02

// Reset values
`define RESET_BYTE 8'h00
`define RESET_SP 16'h0000

`endif

/* src/opdec_pkg.sv */
package opdec_pkg;

  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_PAIR_TO_STACK_POINTER,
    KIND_CMP_REG,
    KIND_CMP_MEM,
    KIND_CMP_IMM,
    KIND_ANI,
    KIND_DAD_SP,
    KIND_RAL,
    KIND_RAR,
    KIND_CALL_COND,
    KIND_RET_COND
  } insn_kind_type;

endpackage

/* src/reg_field_select.sv */
`timescale 1ns/1ns
`include "opdec_cfg.svh"

module reg_field_select (
  // Field and register bank
  input wire logic [2:0] field_i,
  input wire logic [7:0] b_i,
  input wire logic [7:0] c_i,
  input wire logic [7:0] d_i,
  input wire logic [7:0] e_i,
  input wire logic [7:0] h_i,
  input wire logic [7:0] l_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] mem_i,
  // Selection
  output logic [7:0] value_o,
  output logic is_mem_o
);

  assign is_mem_o = field_i == `FIELD_MEM;
  assign value_o = (field_i == `FIELD_B) ? b_i :
                   (field_i == `FIELD_C) ? c_i :
                   (field_i == `FIELD_D) ? d_i :
                   (field_i == `FIELD_E) ? e_i :
                   (field_i == `FIELD_H) ? h_i :
                   (field_i == `FIELD_L) ? l_i :
                   (field_i == `FIELD_A) ? a_i : mem_i;

endmodule // reg_field_select

/* src/alu_unit.sv */
`timescale 1ns/1ns
`include "opdec_cfg.svh"

module alu_unit (
  // Operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] operand_i,
  input wire logic carry_i,
  input wire logic [7:0] flags_i,
  input wire logic [15:0] hl_i,
  input wire logic [15:0] sp_i,
  // Results
  output logic [7:0] cmp_flags_o,
  output logic [7:0] and_result_o,
  output logic [7:0] and_flags_o,
  output logic [7:0] ral_result_o,
  output logic [7:0] rar_result_o,
  output logic [7:0] ral_flags_o,
  output logic [7:0] rar_flags_o,
  output logic [15:0] dad_sum_o,
  output logic [7:0] dad_flags_o
);

  function automatic logic [7:0] pack_flags(input logic s, input logic z, input logic ac,
                                            input logic p, input logic cy);
    logic [7:0] f;
    f = `FLAGS_FIXED;
    f[`FLAG_S_BIT] = s;
    f[`FLAG_Z_BIT] = z;
    f[`FLAG_AC_BIT] = ac;
    f[`FLAG_P_BIT] = p;
    f[`FLAG_CY_BIT] = cy;
    return f;
  endfunction

  function automatic logic [7:0] with_carry(input logic [7:0] f, input logic cy);
    logic [7:0] g;
    g = f;
    g[`FLAG_CY_BIT] = cy;
    return g;
  endfunction

  wire logic [8:0] diff_w = {1'b0, a_i} - {1'b0, operand_i};
  wire logic [4:0] low_sum_w = {1'b0, a_i[3:0]} + {1'b0, ~operand_i[3:0]} + 5'h01;
  wire logic [16:0] dad_w = {1'b0, hl_i} + {1'b0, sp_i};

  // compare flags as a subtraction, borrow in carry
  assign cmp_flags_o = pack_flags(diff_w[7], diff_w[7:0] == 8'h00, low_sum_w[4],
                                  ~^diff_w[7:0], diff_w[8]);
  assign and_result_o = a_i & operand_i;
  assign and_flags_o = pack_flags(and_result_o[7], and_result_o == 8'h00,
                                  a_i[3] | operand_i[3], ~^and_result_o, 1'b0);
  assign ral_result_o = {a_i[6:0], carry_i};
  assign ral_flags_o = with_carry(flags_i, a_i[7]);
  assign rar_result_o = {carry_i, a_i[7:1]};
  assign rar_flags_o = with_carry(flags_i, a_i[0]);
  assign dad_sum_o = dad_w[15:0];
  assign dad_flags_o = with_carry(flags_i, dad_w[16]);

endmodule // alu_unit

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import opdec_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic op_valid_i;
  logic [7:0] opcode_i;
  logic [7:0] operand_i;
  logic wr_en_i;
  logic [2:0] wr_field_i;
  logic [7:0] wr_data_i;
  logic done_o;
  insn_kind_type kind_o;
  logic [4:0] state_count_o;
  logic cond_taken_o;
  logic operand_used_o;
  logic unsupported_o;
  logic [7:0] acc_o;
  logic [15:0] hl_o;
  logic [15:0] sp_o;
  logic [7:0] flags_o;
  int num_errors;
  int checks_done;
  // Bench-side copy of the architectural state; index 6 of rv is unused
  logic [7:0] rv [0:7];
  logic [7:0] ef;
  logic [15:0] esp;

  cpu8_opcode_decode_subset dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .opcode_i(opcode_i),
    .operand_i(operand_i), .wr_en_i(wr_en_i), .wr_field_i(wr_field_i),
    .wr_data_i(wr_data_i), .done_o(done_o), .kind_o(kind_o),
    .state_count_o(state_count_o), .cond_taken_o(cond_taken_o),
    .operand_used_o(operand_used_o), .unsupported_o(unsupported_o), .acc_o(acc_o),
    .hl_o(hl_o), .sp_o(sp_o), .flags_o(flags_o));

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Flags of a subtraction a - b; the accumulator itself is not touched
  function automatic logic [7:0] cmpf(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic [4:0] n;
    d = {1'h0, a} - {1'h0, b};
    n = {1'h0, a[3:0]} + {1'h0, ~b[3:0]} + 5'h01;
    return {d[7], d[7:0] == 8'h00, 1'h0, n[4], 1'h0, ~^d[7:0], 1'h1, d[8]};
  endfunction

  task automatic load(input logic [2:0] f, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'h1;
    wr_field_i <= f;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'h0;
    if (f == 3'h6) ef = (d & 8'hd5) | 8'h02;
    else rv[f] = d;
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] opnd);
    @(posedge clk_i);
    op_valid_i <= 1'h1;
    opcode_i <= op;
    operand_i <= opnd;
    @(posedge clk_i);
    op_valid_i <= 1'h0;
    #1;
    chk("done", 16'h0001, {15'h0000, done_o});
  endtask

  task automatic res(input insn_kind_type k, input logic [4:0] n);
    chk("kind", {12'h000, k}, {12'h000, kind_o});
    chk("count", {11'h000, n}, {11'h000, state_count_o});
    chk("acc", {8'h00, rv[7]}, {8'h00, acc_o});
    chk("hl", {rv[4], rv[5]}, hl_o);
    chk("sp", esp, sp_o);
    chk("flags", {8'h00, ef}, {8'h00, flags_o});
  endtask

  task automatic t_reset();
    res(KIND_NONE, 5'h00);
    chk("done idle", 16'h0000, {15'h0000, done_o});
    $display("reset test done");
  endtask

  // Every source field, memory included, then the immediate form with a borrow
  task automatic t_compare();
    logic [7:0] src;
    for (int i = 0; i < 8; i++) begin
      if (i != 6) load(3'(i), 8'(8'h1d * (i + 1)));
    end
    load(3'h6, 8'h00);
    for (int i = 0; i < 8; i++) begin
      src = (i == 6) ? 8'h5a : rv[i];
      ef = cmpf(rv[7], src);
      run({5'h17, 3'(i)}, 8'h5a);
      res((i == 6) ? KIND_CMP_MEM : KIND_CMP_REG, (i == 6) ? 5'h07 : 5'h04);
      chk("operand used", {15'h0000, i == 6}, {15'h0000, operand_used_o});
    end
    ef = cmpf(rv[7], 8'hf0);
    run(8'hfe, 8'hf0);
    res(KIND_CMP_IMM, 5'h07);
    chk("operand used", 16'h0001, {15'h0000, operand_used_o});
    $display("compare test done");
  endtask

  task automatic t_and();
    logic [7:0] r;
    load(3'h7, 8'hf3);
    load(3'h6, 8'h01);
    r = 8'hf3 & 8'h0f;
    ef = {r[7], r == 8'h00, 1'h0, 1'h1, 1'h0, ~^r, 1'h1, 1'h0};
    rv[7] = r;
    run(8'he6, 8'h0f);
    res(KIND_ANI, 5'h07);
    chk("operand used", 16'h0001, {15'h0000, operand_used_o});
    @(posedge clk_i);
    #1;
    chk("done drop", 16'h0000, {15'h0000, done_o});
    $display("and test done");
  endtask

  task automatic t_pair();
    logic [16:0] s;
    load(3'h4, 8'h90);
    load(3'h5, 8'h12);
    esp = 16'h9012;
    run(8'hf9, 8'h00);
    res(KIND_PAIR_TO_STACK_POINTER, 5'h05);
    s = {1'h0, rv[4], rv[5]} + {1'h0, esp};
    {rv[4], rv[5]} = s[15:0];
    ef[0] = s[16];
    run(8'h39, 8'h00);
    res(KIND_DAD_SP, 5'h0a);
    $display("pair test done");
  endtask

  // Left then right rotate issued back to back
  task automatic t_rotate();
    load(3'h7, 8'h81);
    load(3'h6, 8'h00);
    @(posedge clk_i);
    op_valid_i <= 1'h1;
    opcode_i <= 8'h17;
    @(posedge clk_i);
    opcode_i <= 8'h1f;
    {ef[0], rv[7]} = {rv[7], ef[0]};
    #1;
    res(KIND_RAL, 5'h04);
    @(posedge clk_i);
    op_valid_i <= 1'h0;
    {rv[7], ef[0]} = {ef[0], rv[7]};
    #1;
    res(KIND_RAR, 5'h04);
    chk("done", 16'h0001, {15'h0000, done_o});
    $display("rotate test done");
  endtask

  task automatic t_cond();
    logic tk;
    logic [2:0] idx;
    for (int f = 0; f < 2; f++) begin
      load(3'h6, (f == 0) ? 8'h00 : 8'hd5);
      for (int cc = 0; cc < 8; cc++) begin
        for (int r = 0; r < 2; r++) begin
          idx = (cc[2:1] == 2'h0) ? 3'h6 : (cc[2:1] == 2'h1) ? 3'h0 :
                (cc[2:1] == 2'h2) ? 3'h2 : 3'h7;
          tk = (ef[idx] == cc[0]);
          run({2'h3, 3'(cc), (r == 1) ? 3'h0 : 3'h4}, 8'h00);
          if (r == 1) res(KIND_RET_COND, tk ? 5'h0b : 5'h05);
          else res(KIND_CALL_COND, tk ? 5'h11 : 5'h0b);
          chk("taken", {15'h0000, tk}, {15'h0000, cond_taken_o});
        end
      end
    end
    $display("condition test done");
  endtask

  // Unsupported opcode with a preload in the same cycle: nothing may change
  task automatic t_unsup();
    @(posedge clk_i);
    op_valid_i <= 1'h1;
    opcode_i <= 8'h00;
    wr_en_i <= 1'h1;
    wr_field_i <= 3'h7;
    wr_data_i <= 8'h55;
    @(posedge clk_i);
    op_valid_i <= 1'h0;
    wr_en_i <= 1'h0;
    #1;
    chk("unsupported", 16'h0001, {15'h0000, unsupported_o});
    res(KIND_NONE, 5'h00);
    @(posedge clk_i);
    #1;
    chk("unsupported drop", 16'h0000, {15'h0000, unsupported_o});
    $display("unsupported test done");
  endtask

  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  initial begin
    rst_n_i = 1'h0;
    op_valid_i = 1'h0;
    opcode_i = 8'h00;
    operand_i = 8'h00;
    wr_en_i = 1'h0;
    wr_field_i = 3'h0;
    wr_data_i = 8'h00;
    num_errors = 0;
    checks_done = 0;
    foreach (rv[i]) rv[i] = 8'h00;
    ef = 8'h02;
    esp = 16'h0000;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'h1;
    #1;
    t_reset();
    t_compare();
    t_and();
    t_pair();
    t_rotate();
    t_cond();
    t_unsup();
    conclude();
  end
endmodule // testbench
